// ===== rtl/sfr_pkg.sv
// constants and types shared by the fifo read port and its memory
package sfr_pkg;
    // ------------------------------------------------------------
    // data path and queue shape
    // ------------------------------------------------------------
    localparam int DATA_W = 9;
    localparam int DEPTH = 256;

    // ------------------------------------------------------------
    // flag offsets and reset values
    // ------------------------------------------------------------
    localparam int AE_OFFSET_DEFAULT = 7;
    localparam int AF_OFFSET_DEFAULT = 7;
    localparam logic [8:0] RD_DATA_RESET = 9'h000;

    // ------------------------------------------------------------
    // write port configuration, caught while pointers are cleared
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SFR_MODE_TWO_EN = 2'b01,
        SFR_MODE_LOAD = 2'b10
    } sfr_mode_e;
endpackage

// ===== rtl/sfr_mem.sv
// word storage of the fifo with one write port and a registered read port
`timescale 1ns/1ps
module sfr_mem #(
    parameter int DATA_W = sfr_pkg::DATA_W,
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] rd_data_q;
    logic [DATA_W-1:0] rd_data_d;

    // array left without reset so it maps onto block ram
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_comb begin
        rd_data_d = rd_data_q;
        if (rd_en) begin
            rd_data_d = mem_q[rd_addr];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_q <= sfr_pkg::RD_DATA_RESET;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;
endmodule

// ===== rtl/sfr_fifo.sv
// fifo read port, write port and status flags around the word storage
`timescale 1ns/1ps
// What this block does
// - both read enables low on a clock edge pops one word to the output
// - reads are ignored while the empty flag is low
// - output enable low drives the data bus, high releases it
// - empty flag low when no word is stored, high otherwise
// - empty flag changes only on sys_clk, the one clock shared by both ports, and when nrst goes low
// - almost-empty low when stored count is at or below its offset
// - almost-empty offset is seven after reset until reprogrammed
// - almost-empty flag changes only on sys_clk, the one clock shared by both ports, and when nrst goes low
// - almost-full low when free space is at or below its offset
// - almost-full offset is seven after reset until reprogrammed
// - almost-full flag changes only on sys_clk, the one clock shared by both ports, and when nrst goes low
// - full flag low when every location is used; writes then ignored
// - full flag changes only on sys_clk, the one clock shared by both ports, and when nrst goes low
// - clear empties queue and sets flags; writer clears before first write
// - popped words appear on a nine-bit output bus
// - word stored on clock edge when write enable a low, b high
module sfr_fifo #(
    parameter int DEPTH = sfr_pkg::DEPTH
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic pointer_clear_n,
    input wire logic write_enable_a_n,
    input wire logic write_enable_b_or_load,
    input wire logic [sfr_pkg::DATA_W-1:0] write_data_in,
    input wire logic offset_load,
    input wire logic [$clog2(DEPTH):0] almost_empty_offset_in,
    input wire logic [$clog2(DEPTH):0] almost_full_offset_in,
    input wire logic read_enable_a_n,
    input wire logic read_enable_b_n,
    input wire logic output_drive_enable_n,
    output logic [sfr_pkg::DATA_W-1:0] read_data_out,
    output logic read_data_oe,
    output logic empty_flag_n,
    output logic almost_empty_n,
    output logic almost_full_n,
    output logic full_flag_n,
    output logic load_mode
);
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int PTR_W = ADDR_W + 1;
    localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
    localparam logic [PTR_W-1:0] AE_RST = PTR_W'(sfr_pkg::AE_OFFSET_DEFAULT);
    localparam logic [PTR_W-1:0] AF_RST = PTR_W'(sfr_pkg::AF_OFFSET_DEFAULT);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // pointers carry one extra wrap bit so full and empty differ
    function automatic logic [PTR_W-1:0] occupancy(
        input logic [PTR_W-1:0] wr,
        input logic [PTR_W-1:0] rd
    );
        occupancy = wr - rd;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
    logic [PTR_W-1:0] ae_off_q, ae_off_d;
    logic [PTR_W-1:0] af_off_q, af_off_d;
    logic empty_q, empty_d;
    logic aempty_q, aempty_d;
    logic afull_q, afull_d;
    logic full_q, full_d;
    sfr_pkg::sfr_mode_e mode_q, mode_d;
    logic [PTR_W-1:0] cnt_q;
    logic [PTR_W-1:0] cnt_d;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // request qualification
    // ------------------------------------------------------------
    // flags are active low: the _q copies hold the asserted sense
    assign push = pointer_clear_n && !write_enable_a_n
                  && write_enable_b_or_load && !full_q;
    assign pop = pointer_clear_n && !read_enable_a_n && !read_enable_b_n
                 && !empty_q;
    assign cnt_q = occupancy(wr_ptr_q, rd_ptr_q);

    // ------------------------------------------------------------
    // pointers, offsets and mode
    // ------------------------------------------------------------
    always_comb begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        ae_off_d = ae_off_q;
        af_off_d = af_off_q;
        mode_d = mode_q;
        if (!pointer_clear_n) begin
            wr_ptr_d = '0;
            rd_ptr_d = '0;
            ae_off_d = AE_RST;
            af_off_d = AF_RST;
            // second write pin is sampled as a strap during the clear
            if (write_enable_b_or_load) begin
                mode_d = sfr_pkg::SFR_MODE_TWO_EN;
            end else begin
                mode_d = sfr_pkg::SFR_MODE_LOAD;
            end
        end else begin
            if (push) begin
                wr_ptr_d = wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_d = rd_ptr_q + 1'b1;
            end
            // offsets change only with the load pin held low
            if (mode_q == sfr_pkg::SFR_MODE_LOAD && !write_enable_b_or_load
                && offset_load) begin
                ae_off_d = almost_empty_offset_in;
                af_off_d = almost_full_offset_in;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            ae_off_q <= AE_RST;
            af_off_q <= AF_RST;
            mode_q <= sfr_pkg::SFR_MODE_TWO_EN;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            ae_off_q <= ae_off_d;
            af_off_q <= af_off_d;
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    // one clock serves both ports, so both pointers are already in the
    // flag domain and are compared directly with no crossing latency
    always_comb begin
        cnt_d = occupancy(wr_ptr_d, rd_ptr_d);
        empty_d = (cnt_d == '0);
        aempty_d = (cnt_d <= ae_off_d);
        afull_d = ((DEPTH_P - cnt_d) <= af_off_d);
        full_d = (cnt_d == DEPTH_P);
    end

    // flags are registered from the next count so they never lag a pop
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            empty_q <= 1'b1;
            aempty_q <= 1'b1;
            afull_q <= 1'b0;
            full_q <= 1'b0;
        end else begin
            empty_q <= empty_d;
            aempty_q <= aempty_d;
            afull_q <= afull_d;
            full_q <= full_d;
        end
    end

    assign empty_flag_n = !empty_q;
    assign almost_empty_n = !aempty_q;
    assign almost_full_n = !afull_q;
    assign full_flag_n = !full_q;
    assign load_mode = (mode_q == sfr_pkg::SFR_MODE_LOAD);

    // ------------------------------------------------------------
    // storage and output bus
    // ------------------------------------------------------------
    sfr_mem #(
        .DATA_W(sfr_pkg::DATA_W),
        .ADDR_W(ADDR_W)
    ) u_mem (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .wr_en(push),
        .wr_addr(wr_ptr_q[ADDR_W-1:0]),
        .wr_data(write_data_in),
        .rd_en(pop),
        .rd_addr(rd_ptr_q[ADDR_W-1:0]),
        .rd_data(read_data_out)
    );

    // pad turns the bus to high impedance when the enable is dropped
    assign read_data_oe = !output_drive_enable_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_push_only;
        push && !pop;
    endsequence

    sequence s_pop_only;
        pop && !push;
    endsequence

    sequence s_fill_last;
        push && !pop && cnt_q == DEPTH_P - 1'b1;
    endsequence

    sequence s_drain_last;
        pop && !push && cnt_q == PTR_W'(1);
    endsequence

    chk_pop_advances: assert property (
        pop |=> rd_ptr_q == PTR_W'($past(rd_ptr_q) + 1'b1))
        else $error("pop did not advance read pointer");

    // output word stands until the next pop, even across a clear
    chk_pop_data_out: assert property (
        !pop |=> $stable(read_data_out))
        else $error("read data moved without a pop");

    chk_empty_blocks: assert property (
        (empty_q && !read_enable_a_n && !read_enable_b_n)
            |=> rd_ptr_q == $past(rd_ptr_q) || !$past(pointer_clear_n))
        else $error("read taken while empty");

    chk_drive_follows: assert property (
        read_data_oe != output_drive_enable_n)
        else $error("output enable not followed");

    chk_empty_level: assert property (
        empty_flag_n == (cnt_q != '0))
        else $error("empty flag disagrees with count");

    chk_ae_level: assert property (
        almost_empty_n == (cnt_q > ae_off_q))
        else $error("almost empty disagrees with count");

    chk_ae_default: assert property (
        !pointer_clear_n |=> ae_off_q == AE_RST)
        else $error("almost empty offset not defaulted");

    chk_af_level: assert property (
        almost_full_n == ((DEPTH_P - cnt_q) > af_off_q))
        else $error("almost full disagrees with count");

    chk_af_default: assert property (
        !pointer_clear_n |=> af_off_q == AF_RST)
        else $error("almost full offset not defaulted");

    chk_full_level: assert property (
        full_flag_n == (cnt_q != DEPTH_P))
        else $error("full flag disagrees with count");

    chk_full_blocks: assert property (
        full_q |-> !push)
        else $error("write taken while full");

    chk_clear_flags: assert property (
        !pointer_clear_n |=> !empty_flag_n && !almost_empty_n
            && full_flag_n && almost_full_n && cnt_q == '0)
        else $error("clear did not reset flags");

    chk_push_counts: assert property (
        s_push_only ##1 pointer_clear_n
            |-> cnt_q == PTR_W'($past(cnt_q, 1) + 1'b1))
        else $error("write did not add a word");

    chk_pop_counts: assert property (
        s_pop_only ##1 pointer_clear_n
            |-> cnt_q == PTR_W'($past(cnt_q, 1) - 1'b1))
        else $error("read did not remove a word");

    // offsets move only on a load or a clear
    chk_ae_hold: assert property (
        pointer_clear_n && !offset_load |=> $stable(ae_off_q))
        else $error("almost empty offset moved without a load");

    chk_af_hold: assert property (
        pointer_clear_n && !offset_load |=> $stable(af_off_q))
        else $error("almost full offset moved without a load");

    chk_fill_to_full: assert property (
        s_fill_last |=> !full_flag_n && !almost_full_n)
        else $error("last write did not raise full");

    chk_drain_to_empty: assert property (
        s_drain_last |=> !empty_flag_n && !almost_empty_n)
        else $error("last read did not raise empty");

    chk_full_rises: assert property (
        $rose(full_q) |-> $past(push))
        else $error("full flag rose without a write");

    chk_clear_ignores: assert property (
        !pointer_clear_n |-> !push && !pop)
        else $error("request taken during pointer clear");

    chk_strap_mode: assert property (
        !pointer_clear_n |=> load_mode == !$past(write_enable_b_or_load))
        else $error("write pin strap not captured");
endmodule

// ===== testbench/sfr_reader.sv
// downstream reader model that drives the read port of the fifo
`timescale 1ns/1ps
module sfr_reader (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [1:0] rd_req,
    input wire logic oe_req,
    output logic read_enable_a_n,
    output logic read_enable_b_n,
    output logic output_drive_enable_n
);
    // ------------------------------------------------------------
    // enables change only just after a rising edge or when nrst goes low
    // ------------------------------------------------------------
    // no empty masking here: refused reads must reach the device
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            read_enable_a_n <= 1'b1;
            read_enable_b_n <= 1'b1;
            output_drive_enable_n <= 1'b1;
        end else begin
            read_enable_a_n <= !rd_req[0];
            read_enable_b_n <= !rd_req[1];
            output_drive_enable_n <= !oe_req;
        end
    end
endmodule

// ===== testbench/sfr_fifo_tb_top.sv
// self-checking bench for the fifo read port and flags
`timescale 1ns/1ps
module sfr_fifo_tb_top;
    localparam int DEPTH = 16;
    logic sys_clk, nrst, pointer_clear_n, write_enable_a_n;
    logic write_enable_b_or_load, offset_load, oe_req;
    logic [8:0] write_data_in, read_data_out;
    logic [4:0] ae_in, af_in;
    logic [1:0] rd_req;
    logic read_enable_a_n, read_enable_b_n, output_drive_enable_n;
    logic read_data_oe, empty_flag_n, almost_empty_n, almost_full_n;
    logic full_flag_n, load_mode;
    logic [31:0] seed = 32'h0000005b;
    logic [8:0] exp_q[$];
    int cnt, aoff, foff, n_fail, total_checks;
    logic mode;

    sfr_fifo #(.DEPTH(DEPTH)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .pointer_clear_n(pointer_clear_n),
        .write_enable_a_n(write_enable_a_n),
        .write_enable_b_or_load(write_enable_b_or_load),
        .write_data_in(write_data_in), .offset_load(offset_load),
        .almost_empty_offset_in(ae_in), .almost_full_offset_in(af_in),
        .read_enable_a_n(read_enable_a_n),
        .read_enable_b_n(read_enable_b_n),
        .output_drive_enable_n(output_drive_enable_n),
        .read_data_out(read_data_out), .read_data_oe(read_data_oe),
        .empty_flag_n(empty_flag_n), .almost_empty_n(almost_empty_n),
        .almost_full_n(almost_full_n), .full_flag_n(full_flag_n),
        .load_mode(load_mode));
    sfr_reader reader (.sys_clk(sys_clk), .nrst(nrst), .rd_req(rd_req),
        .oe_req(oe_req), .read_enable_a_n(read_enable_a_n),
        .read_enable_b_n(read_enable_b_n),
        .output_drive_enable_n(output_drive_enable_n));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = !sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one clock of traffic with fresh random data and output enable
    task automatic cyc(input logic we, input logic [1:0] rr);
        @(posedge sys_clk);
        seed = xs(seed);
        write_enable_a_n <= !we;
        write_data_in <= seed[8:0];
        rd_req <= rr;
        oe_req <= seed[9];
    endtask

    task automatic clear(input logic strap);
        @(posedge sys_clk);
        pointer_clear_n <= 1'b0;
        write_enable_b_or_load <= strap;
        cyc(1'b1, 2'b11);
        @(posedge sys_clk);
        pointer_clear_n <= 1'b1;
        write_enable_b_or_load <= 1'b1;
    endtask

    task automatic fill_drain(input string name);
        int i;
        repeat (DEPTH + 4) cyc(1'b1, 2'b00);
        for (i = 0; i < 60 && empty_flag_n !== 1'b0; i++)
            cyc(1'b0, 2'b11);
        if (i == 60) begin
            n_fail++;
            $display("ERROR %0t drain never reached empty", $time);
            tally_and_finish();
        end
        repeat (4) cyc(1'b0, 2'b11);
        $display("%s done", name);
    endtask

    // model of stored count and offsets, judged after each edge
    initial begin : watch
        logic w, r;
        logic [8:0] exp_d;
        forever begin
            @(posedge sys_clk);
            w = !write_enable_a_n && write_enable_b_or_load && cnt < DEPTH;
            r = !read_enable_a_n && !read_enable_b_n && cnt > 0;
            if (!nrst || !pointer_clear_n) begin
                cnt = 0;
                aoff = 7;
                foff = 7;
                mode = nrst && !write_enable_b_or_load;
                r = 1'b0;
                exp_q.delete();
            end else begin
                if (mode && !write_enable_b_or_load && offset_load) begin
                    aoff = int'(ae_in);
                    foff = int'(af_in);
                end
                if (r) exp_d = exp_q.pop_front();
                if (w) exp_q.push_back(write_data_in);
                cnt = cnt + int'(w) - int'(r);
            end
            #1;
            if (r) chk(read_data_out, exp_d);
            chk({8'h00, empty_flag_n}, {8'h00, cnt != 0});
            chk({8'h00, almost_empty_n}, {8'h00, cnt > aoff});
            chk({8'h00, almost_full_n}, {8'h00, DEPTH - cnt > foff});
            chk({8'h00, full_flag_n}, {8'h00, cnt != DEPTH});
            chk({8'h00, read_data_oe}, {8'h00, !output_drive_enable_n});
            chk({8'h00, load_mode}, {8'h00, mode});
        end
    end

    initial begin
        nrst = 1'b0;
        pointer_clear_n = 1'b1;
        write_enable_a_n = 1'b1;
        write_enable_b_or_load = 1'b1;
        write_data_in = 9'h000;
        offset_load = 1'b0;
        ae_in = 5'h00;
        af_in = 5'h00;
        rd_req = 2'b00;
        oe_req = 1'b0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        clear(1'b1);
        fill_drain("default offsets");
        repeat (300) begin
            seed = xs(seed);
            cyc(seed[10], seed[12:11]);
        end
        $display("random traffic done");
        clear(1'b0);
        @(posedge sys_clk);
        write_enable_b_or_load <= 1'b0;
        offset_load <= 1'b1;
        ae_in <= 5'h03;
        af_in <= 5'h02;
        @(posedge sys_clk);
        offset_load <= 1'b0;
        write_enable_b_or_load <= 1'b1;
        fill_drain("loaded offsets");
        repeat (10) cyc(1'b1, 2'b00);
        clear(1'b1);
        repeat (10) cyc(1'b1, 2'b11);
        cyc(1'b0, 2'b00);
        @(negedge sys_clk);
        nrst = 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        clear(1'b1);
        fill_drain("after reset");
        tally_and_finish();
    end
endmodule
